// [core/sec_defs.vh]
`ifndef SEC_DEFS_VH
`define SEC_DEFS_VH

// ****************************************
// Opcodes and extended sub-commands
// ****************************************
`define SEC_OP_EXT         2'b00
`define SEC_OP_WRITE       2'b01
`define SEC_OP_READ        2'b10
`define SEC_OP_ERASE       2'b11
`define SEC_EXT_DISABLE    2'b00
`define SEC_EXT_FILL       2'b01
`define SEC_EXT_CLEAR      2'b10
`define SEC_EXT_ENABLE     2'b11

// ****************************************
// Field lengths and layout
// ****************************************
`define SEC_OPC_LAST       5'h01
`define SEC_BYTE_BITS      5'h08
`define SEC_WORD_BITS      5'h10
`define SEC_PAGE_BYTES     16
`define SEC_PAGE_IDX       4
`define SEC_PAGE_LAST      4'hf
`define SEC_MSB_WORD       15
`define SEC_MSB_BYTE       7
`define SEC_ERASED_WORD    16'hffff
`define SEC_DATA_BITS      16

// ****************************************
// Timing
// ****************************************
`define SEC_T_PROG_NS      3000000
`define SEC_CLK_PERIOD_NS  20
`define SEC_PROG_CYCLES    (`SEC_T_PROG_NS / `SEC_CLK_PERIOD_NS)
`define SEC_TIMER_BITS     24

// ****************************************
// Sizes
// ****************************************
`define SEC_ADDR_BITS      6
`define SEC_FIFO_DEPTH     8
`define SEC_SYNC_STAGES    3

`endif

// [core/sec_sync.v]
`timescale 1ns/1ps

// ****************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************
module sec_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Pins
	input  wire [WIDTH-1:0] async_in,
	// Filtered levels
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] ff1;
	reg [WIDTH-1:0] ff2;
	reg [WIDTH-1:0] ff3;
	genvar g;

	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			always @(posedge clk) begin
				if (rst) begin
					ff1[g]      <= 1'b0;
					ff2[g]      <= 1'b0;
					ff3[g]      <= 1'b0;
					sync_out[g] <= 1'b0;
				end else begin
					ff1[g] <= async_in[g];
					ff2[g] <= ff1[g];
					ff3[g] <= ff2[g];
					// Change counts only once two stages agree
					if (ff2[g] == ff3[g])
						sync_out[g] <= ff3[g];
				end
			end
		end
	endgenerate
endmodule // sec_sync

// [core/sec_fifo.v]
`timescale 1ns/1ps

// ****************************************
// Small valid/ready FIFO
// ****************************************
module sec_fifo #(
	parameter WIDTH = 23,
	parameter DEPTH = 8,
	parameter PTR_W = 3
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [PTR_W:0]   wptr;
	reg [PTR_W:0]   rptr;

	wire empty = (wptr == rptr);
	wire full  = (wptr[PTR_W] != rptr[PTR_W]) && (wptr[PTR_W-1:0] == rptr[PTR_W-1:0]);

	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = store[rptr[PTR_W-1:0]];

	always @(posedge clk) begin
		if (rst) begin
			wptr <= {(PTR_W+1){1'b0}};
			rptr <= {(PTR_W+1){1'b0}};
		end else begin
			if (in_valid && !full) begin
				store[wptr[PTR_W-1:0]] <= in_data;
				wptr                   <= wptr + 1'b1;
			end
			if (out_ready && !empty)
				rptr <= rptr + 1'b1;
		end
	end
endmodule // sec_fifo

// [core/sec_engine.v]
`timescale 1ns/1ps
`include "sec_defs.vh"

// Operation
// - Instruction is start one, 2-bit opcode, address field, then data for writes.
// - Data input bits are sampled on each serial clock rising edge.
// - Read drives output, sends a dummy zero, then the word MSB first.
// - Read output bits change on serial clock rising edges.
// - Continued clocking reads the next word, wrapping top address to zero.
// - Only the first word of a sequential read has a dummy zero.
// - Deselect after a write starts a self-timed clear-then-store cycle.
// - Locations are cleared automatically before storing, no erase needed.
// - Reselect during programming shows busy low, ready high on output.
// - A one shifted in while polling returns the output to high impedance.
// - One write takes up to 16 bytes or 8 words in one cycle.
// - Page pointer advances every 8 clocks (x8) or 16 clocks (x16).
// - Extra page data wraps within the page, overwriting earlier data.
// - Erase plus deselect clears the location to all ones.
// - Enable latch clear from power-up; programming refused until enabled.
// - Enable latch stays set until power loss or disable command.
// - Write, erase, clear-all and fill-all are ignored with latch clear.
// - Reads work regardless of the enable latch.
// - Clear-all plus deselect sets every bit of the array to one.
// - Fill-all plus deselect writes its data to every location.
module sec_engine #(
	parameter ADDR_BITS   = `SEC_ADDR_BITS,
	parameter PROG_CYCLES = `SEC_PROG_CYCLES,
	parameter FIFO_DEPTH  = `SEC_FIFO_DEPTH
) (
	// Clock and reset
	input  wire ref_clk,
	input  wire rst,
	// Serial pins
	input  wire chip_select,
	input  wire serial_clock_in,
	input  wire serial_in,
	input  wire word_width_select,
	output reg  serial_out,
	output reg  serial_out_en,
	// Status
	output wire program_busy
);
	localparam AW     = ADDR_BITS + 1;
	localparam NBYTES = 1 << AW;
	localparam EW     = 1 + AW + `SEC_DATA_BITS;
	localparam [4:0] ABITS16 = ADDR_BITS;
	localparam [4:0] ABITS8  = ADDR_BITS + 1;
	localparam [`SEC_TIMER_BITS-1:0] PROG_LAST = PROG_CYCLES - 1;

	localparam S_IDLE = 3'd0;
	localparam S_OPC  = 3'd1;
	localparam S_ADDR = 3'd2;
	localparam S_DATA = 3'd3;
	localparam S_READ = 3'd4;
	localparam S_DONE = 3'd5;

	localparam P_IDLE  = 2'd0;
	localparam P_DRAIN = 2'd1;
	localparam P_STORE = 2'd2;
	localparam P_WAIT  = 2'd3;

	// ****************************************
	// Pin sampling and edges
	// ****************************************
	wire [3:0] pins;

	sec_sync #(
		.WIDTH (4)
	) u_sync (
		.clk      (ref_clk),
		.rst      (rst),
		.async_in ({chip_select, serial_clock_in, serial_in, word_width_select}),
		.sync_out (pins)
	);

	wire cs   = pins[3];
	wire sk   = pins[2];
	wire si   = pins[1];
	wire wide = pins[0];

	reg cs_q;
	reg sk_q;

	always @(posedge ref_clk) begin
		if (rst) begin
			cs_q <= 1'b0;
			sk_q <= 1'b0;
		end else begin
			cs_q <= cs;
			sk_q <= sk;
		end
	end

	wire sk_rise = sk & ~sk_q;
	wire sk_fall = ~sk & sk_q;
	wire cs_rise = cs & ~cs_q;
	wire cs_fall = ~cs & cs_q;

	// ****************************************
	// Storage
	// ****************************************
	// Array is nonvolatile: never reset, content unknown until programmed
	reg [7:0]     mem   [0:NBYTES-1];
	reg [7:0]     latch [0:`SEC_PAGE_BYTES-1];
	reg [15:0]    lmask;
	reg [AW-5:0]  lbase;

	// ****************************************
	// Serial decode state
	// ****************************************
	reg [2:0]     sstate;
	reg [4:0]     cnt;
	reg [1:0]     opc;
	reg [AW-1:0]  addr;
	reg [15:0]    din;
	reg [AW-1:0]  wba;
	reg [AW-1:0]  rd_addr;
	reg [15:0]    shreg;
	reg           wel;
	reg           stat;
	reg           poll;
	reg           poll_one;
	reg           pend_page;
	reg           pend_fill;
	reg [15:0]    fill_val;
	reg           push_valid;
	reg [EW-1:0]  push_data;

	reg [1:0]     pstate;
	reg [AW-1:0]  idx;
	reg           pfill;
	reg           pwide;
	reg [15:0]    pval;
	reg [`SEC_TIMER_BITS-1:0] timer;
	reg           prog_done;

	wire          f_in_ready;
	wire          f_valid;
	wire [EW-1:0] f_data;
	wire          f_ready = (pstate != P_STORE);
	wire          busy    = (pstate != P_IDLE);

	assign program_busy = busy;

	wire [4:0]    abits     = wide ? ABITS16 : ABITS8;
	wire [4:0]    dbits     = wide ? `SEC_WORD_BITS : `SEC_BYTE_BITS;
	wire [AW-1:0] full_addr = {addr[AW-2:0], si};
	wire [1:0]    ext_sel   = wide ? full_addr[ADDR_BITS-1 -: 2] : full_addr[AW-1 -: 2];
	wire [AW-1:0] byte_of   = wide ? {full_addr[ADDR_BITS-1:0], 1'b0} : full_addr;
	wire [15:0]   unit      = {din[14:0], si};
	wire [3:0]    step      = {2'b00, wide, ~wide};
	wire [3:0]    wba_lo    = wba[3:0] + step;

	wire [AW-1:0] rd_ba   = wide ? {rd_addr[ADDR_BITS-1:0], 1'b0} : rd_addr;
	wire [15:0]   rd_word = wide ? {mem[rd_ba], mem[{rd_ba[AW-1:1], 1'b1}]} : {8'h00, mem[rd_ba]};
	wire [AW-1:0] rd_inc  = rd_addr + {{(AW-1){1'b0}}, 1'b1};
	wire [AW-1:0] rd_next = wide ? {1'b0, rd_inc[AW-2:0]} : rd_inc;
	wire          rd_bit  = wide ? rd_word[`SEC_MSB_WORD] : rd_word[`SEC_MSB_BYTE];
	wire          sh_bit  = wide ? shreg[`SEC_MSB_WORD] : shreg[`SEC_MSB_BYTE];

	wire commit = cs_fall & (pend_page | pend_fill) & ~busy;

	// ****************************************
	// Serial command state machine
	// ****************************************
	always @(posedge ref_clk) begin
		if (rst) begin
			sstate     <= S_IDLE;
			cnt        <= 5'h00;
			opc        <= 2'b00;
			addr       <= {AW{1'b0}};
			din        <= 16'h0000;
			wba        <= {AW{1'b0}};
			rd_addr    <= {AW{1'b0}};
			shreg      <= 16'h0000;
			serial_out <= 1'b0;
			serial_out_en <= 1'b0;
			wel        <= 1'b0;
			stat       <= 1'b0;
			poll       <= 1'b0;
			poll_one   <= 1'b0;
			pend_page  <= 1'b0;
			pend_fill  <= 1'b0;
			fill_val   <= 16'h0000;
			push_valid <= 1'b0;
			push_data  <= {EW{1'b0}};
		end else begin
			if (push_valid && f_in_ready)
				push_valid <= 1'b0;
			if (cs_fall) begin
				sstate        <= S_IDLE;
				serial_out_en <= 1'b0;
				stat          <= 1'b0;
				pend_page     <= 1'b0;
				pend_fill     <= 1'b0;
				poll_one      <= 1'b0;
				if (commit)
					poll <= 1'b1;
			end else if (cs) begin
				if (cs_rise && poll) begin
					stat          <= 1'b1;
					serial_out_en <= 1'b1;
					serial_out    <= ~busy;
					poll_one      <= 1'b0;
				end else if (stat) begin
					serial_out <= ~busy;
					// One taken on a rise, released on the next fall
					// Input may already hold the next bit at the fall, so sample at the rise
					if (sk_rise && si)
						poll_one <= 1'b1;
					if (sk_fall && poll_one) begin
						stat          <= 1'b0;
						serial_out_en <= 1'b0;
						poll          <= 1'b0;
						poll_one      <= 1'b0;
					end
				end
				if (sk_rise) begin
					case (sstate)
					S_IDLE: begin
						if (si && !busy) begin
							sstate <= S_OPC;
							cnt    <= 5'h00;
						end
					end
					S_OPC: begin
						opc <= {opc[0], si};
						if (cnt == `SEC_OPC_LAST) begin
							sstate <= S_ADDR;
							cnt    <= 5'h00;
						end else begin
							cnt <= cnt + 5'h01;
						end
					end
					S_ADDR: begin
						addr <= full_addr;
						if (cnt == abits - 5'h01) begin
							cnt <= 5'h00;
							case (opc)
							`SEC_OP_READ: begin
								sstate        <= S_READ;
								serial_out    <= 1'b0;
								serial_out_en <= 1'b1;
								rd_addr       <= wide ? {1'b0, full_addr[AW-2:0]} : full_addr;
							end
							`SEC_OP_WRITE: begin
								wba    <= byte_of;
								sstate <= wel ? S_DATA : S_DONE;
							end
							`SEC_OP_ERASE: begin
								sstate <= S_DONE;
								if (wel) begin
									push_valid <= 1'b1;
									push_data  <= {wide, byte_of, `SEC_ERASED_WORD};
									pend_page  <= 1'b1;
								end
							end
							default: begin
								case (ext_sel)
								`SEC_EXT_DISABLE: begin
									wel    <= 1'b0;
									sstate <= S_DONE;
								end
								`SEC_EXT_ENABLE: begin
									wel    <= 1'b1;
									sstate <= S_DONE;
								end
								`SEC_EXT_CLEAR: begin
									sstate <= S_DONE;
									if (wel) begin
										fill_val  <= `SEC_ERASED_WORD;
										pend_fill <= 1'b1;
									end
								end
								default: begin
									sstate <= wel ? S_DATA : S_DONE;
								end
								endcase
							end
							endcase
						end else begin
							cnt <= cnt + 5'h01;
						end
					end
					S_DATA: begin
						din <= unit;
						if (cnt == dbits - 5'h01) begin
							cnt <= 5'h00;
							if (opc == `SEC_OP_EXT) begin
								fill_val  <= unit;
								pend_fill <= 1'b1;
								sstate    <= S_DONE;
							end else begin
								push_valid <= 1'b1;
								push_data  <= {wide, wba, unit};
								pend_page  <= 1'b1;
								wba[3:0]   <= wba_lo;
							end
						end else begin
							cnt <= cnt + 5'h01;
						end
					end
					S_READ: begin
						if (cnt == 5'h00) begin
							serial_out <= rd_bit;
							shreg      <= rd_word << 1;
						end else begin
							serial_out <= sh_bit;
							shreg      <= shreg << 1;
						end
						if (cnt == dbits - 5'h01) begin
							cnt <= 5'h00;
							rd_addr <= rd_next;
						end else begin
							cnt <= cnt + 5'h01;
						end
					end
					default: begin
						sstate <= sstate;
					end
					endcase
				end
			end
		end
	end

	// ****************************************
	// Page data path
	// ****************************************
	sec_fifo #(
		.WIDTH (EW),
		.DEPTH (FIFO_DEPTH),
		.PTR_W (3)
	) u_fifo (
		.clk       (ref_clk),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_ready  (f_in_ready),
		.in_data   (push_data),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	wire          e_wide = f_data[EW-1];
	wire [AW-1:0] e_ba   = f_data[AW+15:16];
	wire [15:0]   e_dat  = f_data[15:0];
	wire [3:0]    e_idx  = e_ba[3:0];
	wire [3:0]    e_idx1 = e_idx + 4'h1;

	// Latch empties when a command aborts or its cycle ends
	always @(posedge ref_clk) begin
		if (rst) begin
			lmask <= 16'h0000;
			lbase <= {(AW-4){1'b0}};
		end else if (prog_done || (cs_fall && !commit && !busy)) begin
			lmask <= 16'h0000;
		end else if (f_valid && f_ready) begin
			lbase <= e_ba[AW-1:`SEC_PAGE_IDX];
			if (e_wide) begin
				latch[e_idx]  <= e_dat[15:8];
				latch[e_idx1] <= e_dat[7:0];
				lmask[e_idx]  <= 1'b1;
				lmask[e_idx1] <= 1'b1;
			end else begin
				latch[e_idx] <= e_dat[7:0];
				lmask[e_idx] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Self-timed programming
	// ****************************************
	always @(posedge ref_clk) begin
		if (rst) begin
			pstate    <= P_IDLE;
			idx       <= {AW{1'b0}};
			pfill     <= 1'b0;
			pwide     <= 1'b0;
			pval      <= 16'h0000;
			timer     <= {`SEC_TIMER_BITS{1'b0}};
			prog_done <= 1'b0;
		end else begin
			prog_done <= 1'b0;
			case (pstate)
			P_IDLE: begin
				if (commit) begin
					pstate <= P_DRAIN;
					pfill  <= pend_fill;
					pwide  <= wide;
					pval   <= fill_val;
					idx    <= {AW{1'b0}};
				end
			end
			P_DRAIN: begin
				// Wait for page entries still in flight
				if (!f_valid && !push_valid)
					pstate <= P_STORE;
			end
			P_STORE: begin
				if (pfill) begin
					if (pwide && !idx[0])
						mem[idx] <= pval[15:8];
					else
						mem[idx] <= pval[7:0];
					if (idx == NBYTES - 1)
						pstate <= P_WAIT;
				end else begin
					if (lmask[idx[3:0]])
						mem[{lbase, idx[3:0]}] <= latch[idx[3:0]];
					if (idx[3:0] == `SEC_PAGE_LAST)
						pstate <= P_WAIT;
				end
				idx   <= idx + {{(AW-1){1'b0}}, 1'b1};
				timer <= {`SEC_TIMER_BITS{1'b0}};
			end
			default: begin
				if (timer == PROG_LAST) begin
					pstate    <= P_IDLE;
					prog_done <= 1'b1;
				end else begin
					timer <= timer + 1'b1;
				end
			end
			endcase
		end
	end
endmodule // sec_engine

// [test/sec_engine_checker.sv]
`timescale 1ns/1ps
// ****
// Port-level checks
// ****
module sec_engine_checker (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Serial pins
	input wire chip_select,
	input wire serial_clock_in,
	input wire serial_in,
	input wire word_width_select,
	input wire serial_out,
	input wire serial_out_en,
	// Status
	input wire program_busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence deselect_s;
		$fell(chip_select);
	endsequence
	sequence poll_one_s;
		serial_out_en && !program_busy && serial_in ##1 $rose(serial_clock_in);
	endsequence

	reset_quiet_a: assert property ($fell(rst) |-> !serial_out_en && !program_busy)
		else $error("outputs active after reset");
	busy_cause_a: assert property ($rose(program_busy) |-> !$past(chip_select, 2))
		else $error("busy without deselect");
	busy_length_a: assert property ($rose(program_busy) |=> program_busy [*8])
		else $error("programming cycle cut short");
	busy_level_a: assert property (program_busy && $past(program_busy) && serial_out_en
		&& $past(serial_out_en) |-> !serial_out)
		else $error("status not low while busy");
	drive_select_a: assert property ($rose(serial_out_en) |-> $past(chip_select, 2))
		else $error("output driven while deselected");
	deselect_release_a: assert property (deselect_s |-> ##[1:8] !serial_out_en)
		else $error("output kept after deselect");
	out_pace_a: assert property ($rose(serial_clock_in) |=> $stable(serial_out) [*2])
		else $error("output moved too soon after clock");
	poll_release_a: assert property (poll_one_s |-> ##[1:14] !serial_out_en)
		else $error("status output not released");
endmodule // sec_engine_checker

bind sec_engine sec_engine_checker i_chk (
	.ref_clk(ref_clk), .rst(rst), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
	.serial_in(serial_in), .word_width_select(word_width_select), .serial_out(serial_out),
	.serial_out_en(serial_out_en), .program_busy(program_busy));

// [test/sec_host_model.sv]
`timescale 1ns/1ps
// ****
// Host controller on the link
// ****
module sec_host_model (
	// Clock
	input  wire ref_clk,
	// Link
	output reg  chip_select,
	output reg  serial_clock_in,
	output reg  serial_in,
	input  wire serial_out,
	input  wire serial_out_en
);
	initial begin
		chip_select = 1'b0;
		serial_clock_in = 1'b0;
		serial_in = 1'b0;
	end
	task tick(input integer n);
		begin
			repeat (n) @(posedge ref_clk);
			#1;
		end
	endtask
	task frame_start;
		begin
			chip_select = 1'b1;
			tick(4);
		end
	endtask
	task xfer(input [31:0] v, input integer n, output [31:0] r);
		integer k;
		begin
			r = 32'h0;
			for (k = n - 1; k >= 0; k = k - 1) begin
				serial_in = v[k];
				tick(4);
				// Released line reads as inverse of last bit
				r = {r[30:0], serial_out_en ? serial_out : ~r[0]};
				// Link clock idles low, so two toggles make one full period
				serial_clock_in = ~serial_clock_in;
				tick(4);
				serial_clock_in = ~serial_clock_in;
			end
		end
	endtask
	task frame_end;
		begin
			tick(4);
			chip_select = 1'b0;
			serial_in = ~serial_in;
			tick(8);
		end
	endtask
endmodule // sec_host_model

// [test/sec_engine_test.sv]
`timescale 1ns/1ps
module sec_engine_test;
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg         word_width_select = 1'b1;
	wire        chip_select, serial_clock_in, serial_in;
	wire        serial_out, serial_out_en, program_busy;
	reg  [7:0]  mem [0:127];
	reg  [31:0] r;
	reg  [15:0] d;
	reg         wen = 1'b0;
	integer     n_mismatch = 0, tests_run = 0, t = 0, i, k, p;

	always #10 ref_clk = ~ref_clk;

	sec_engine #(.PROG_CYCLES(20)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
		.serial_in(serial_in), .word_width_select(word_width_select), .serial_out(serial_out),
		.serial_out_en(serial_out_en), .program_busy(program_busy));
	sec_host_model i_host (
		.ref_clk(ref_clk), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
		.serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));

	// ****
	// Checking and command tasks
	// ****
	task chk_word(input [15:0] g, input [15:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: got %h, expected %h", $time, g, e);
			end
		end
	endtask
	task chk_bit(input g, input e);
		chk_word({15'h0, g}, {15'h0, e});
	endtask
	task done;
		begin
			t = t + 1;
			$display("test %0d done", t);
		end
	endtask
	task send(input [31:0] v, input integer n);
		begin
			i_host.frame_start;
			i_host.xfer(v, n, r);
		end
	endtask
	task ext(input [1:0] sub);
		send({23'h0, 3'b100, sub, 4'h0}, 9);
	endtask
	task finish_cmd(input launch);
		begin
			i_host.frame_end;
			chk_bit(program_busy, launch);
			k = 0;
			while (program_busy !== 1'b0 && k < 600) begin
				i_host.tick(1);
				k = k + 1;
			end
			chk_bit(k < 600, 1'b1);
		end
	endtask
	task rd(input integer a, input integer n);
		begin
			send({23'h0, 3'b110, a[5:0]}, 9);
			i_host.xfer(32'h0, 17, r);
			chk_bit(r[16], 1'b0);
			for (p = 0; p < n; p = p + 1) begin
				if (p > 0)
					i_host.xfer(32'h0, 16, r);
				chk_word(r[15:0], {mem[2*a], mem[2*a+1]});
				a = (a + 1) % 64;
			end
			finish_cmd(1'b0);
		end
	endtask
	task wr(input integer a, input integer n);
		begin
			send({23'h0, 3'b101, a[5:0]}, 9);
			for (p = 0; p < n; p = p + 1) begin
				d = $urandom;
				i_host.xfer({16'h0, d}, 16, r);
				// Pointer wraps inside the 8-word page
				k = (a & 56) + ((a + p) & 7);
				if (wen)
					{mem[2*k], mem[2*k+1]} = d;
			end
			finish_cmd(wen);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d, mismatches %0d", tests_run, n_mismatch);
			if (n_mismatch == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch = n_mismatch + 1;
		final_report;
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		#1 rst = 1'b0;
		i = $urandom(32'hfe56);
		i_host.tick(2);
		wr(0, 1);
		ext(2'b01);
		i_host.xfer(32'h1234, 16, r);
		finish_cmd(1'b0);
		done;
		ext(2'b11);
		finish_cmd(1'b0);
		wen = 1'b1;
		ext(2'b10);
		finish_cmd(1'b1);
		for (i = 0; i < 128; i = i + 1)
			mem[i] = 8'hff;
		ext(2'b00);
		finish_cmd(1'b0);
		wen = 1'b0;
		send({23'h0, 3'b111, 6'h04}, 9);
		finish_cmd(1'b0);
		rd(0, 3);
		done;
		ext(2'b11);
		finish_cmd(1'b0);
		wen = 1'b1;
		send({23'h0, 3'b101, 6'h03}, 9);
		i_host.xfer(32'h5a, 8, r);
		finish_cmd(1'b0);
		wr(13, 9);
		rd(8, 8);
		rd(62, 4);
		done;
		send({23'h0, 3'b111, 6'h0d}, 9);
		finish_cmd(1'b1);
		{mem[26], mem[27]} = 16'hffff;
		wr(14, 1);
		rd(13, 2);
		done;
		word_width_select = 1'b0;
		i = $urandom % 128;
		d = $urandom;
		send({22'h0, 3'b101, i[6:0]}, 10);
		i_host.xfer({24'h0, d[7:0]}, 8, r);
		mem[i] = d[7:0];
		finish_cmd(1'b1);
		send({20'h0, 5'b00110, i[6:0]}, 12);
		i_host.xfer(32'h0, 9, r);
		chk_bit(r[8], 1'b0);
		chk_word({8'h0, r[7:0]}, {8'h0, mem[i]});
		finish_cmd(1'b0);
		word_width_select = 1'b1;
		done;
		ext(2'b01);
		d = $urandom;
		i_host.xfer({16'h0, d}, 16, r);
		finish_cmd(1'b1);
		for (i = 0; i < 64; i = i + 1)
			{mem[2*i], mem[2*i+1]} = d;
		rd(63, 2);
		done;
		send({23'h0, 3'b101, 6'h14}, 9);
		d = $urandom;
		i_host.xfer({16'h0, d}, 16, r);
		{mem[40], mem[41]} = d;
		i_host.frame_end;
		chk_bit(program_busy, 1'b1);
		i_host.frame_start;
		i_host.tick(4);
		chk_bit(serial_out_en, 1'b1);
		chk_bit(serial_out, 1'b0);
		k = 0;
		while (serial_out !== 1'b1 && k < 600) begin
			i_host.tick(1);
			k = k + 1;
		end
		chk_bit(k < 600, 1'b1);
		chk_bit(program_busy, 1'b0);
		i_host.xfer(32'h1, 1, r);
		i_host.tick(8);
		chk_bit(serial_out_en, 1'b0);
		i_host.frame_end;
		rd(20, 1);
		done;
		final_report;
	end
endmodule // sec_engine_test
